/* File: hdl/ddr_sram_device.sv */
// memory end: burst-of-four double data rate static memory on a shared data bus
// assumes the link clocks come from the controller; reset and loop disable are pins
`timescale 1ns/1ps
module ddr_sram_device #(
  parameter int MEM_ADDR_W = ddr_burst_pkg::ADDR_W
) (
  ddr_link_if.device_end link,
  input wire logic reset,
  input wire logic loop_disable_n,
  output logic dll_active
);
  // short names for the package widths; only the x36 build is carried
  localparam int DW = ddr_burst_pkg::DATA_W;
  localparam int AW = ddr_burst_pkg::ADDR_W;
  localparam int BN = ddr_burst_pkg::BYTE_N;
  localparam int BL = ddr_burst_pkg::BURST;
  localparam int HW = ddr_burst_pkg::HIST_W;
  localparam int AP = ddr_burst_pkg::ADDR_PIPE;

  // state registered on the main link clock rise
  typedef struct packed {
    logic [2:0] rst_sync;
    logic rst;
    logic [2:0] dll_sync;
    logic dll_on;
    logic took;
    logic [HW-1:0] rd_hist;
    logic [HW-1:0] wr_hist;
    logic [AP-1:0][AW-1:0] rd_addr;
    logic [AP-1:0][AW-1:0] wr_addr;
    logic [BL-1:0][DW-1:0] rbuf;
    logic go_b0;
    logic go_b2;
    logic [DW-1:0] wb0;
    logic [BN-1:0] be0;
    logic [DW-1:0] wb2;
    logic [BN-1:0] be2;
    logic [DW-1:0] q;
    logic q_valid;
    logic tog;
  } kside_t;

  // state registered on the inverted link clock rise
  typedef struct packed {
    logic [DW-1:0] din;
    logic [BN-1:0] be_n;
    logic [DW-1:0] q;
    logic q_valid;
    logic tog;
  } nside_t;

  kside_t ks_r;
  kside_t ks_nxt;
  nside_t ns_r;
  nside_t ns_nxt;
  // decode helpers of the main clock side
  int lat;
  logic accept;
  logic echo;

  // four words per burst address; never cleared, so unwritten words read unknown
  logic [DW-1:0] mem [0:(2**MEM_ADDR_W)*BL-1];

  // word index of one beat of a burst address
  function automatic logic [MEM_ADDR_W+1:0] beat_idx(input logic [AW-1:0] a,
                                                       input logic [1:0] b);
    beat_idx = {a[MEM_ADDR_W-1:0], b};
  endfunction

  // keep bytes whose enable is high, take the new byte where it is low
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w, input logic [DW-1:0] new_w,
                                          input logic [BN-1:0] be_n);
    logic [DW-1:0] m;
    m = old_w;
    for (int i = 0; i < BN; i++) begin
      if (!be_n[i]) begin
        m[i*ddr_burst_pkg::BYTE_W +: ddr_burst_pkg::BYTE_W] =
          new_w[i*ddr_burst_pkg::BYTE_W +: ddr_burst_pkg::BYTE_W];
      end
    end
    merge = m;
  endfunction

  // main clock side: command capture, read launch, write collection
  always_comb begin
    ks_nxt = ks_r;

    // reset and loop disable are pins: three flops, change taken once two agree
    ks_nxt.rst_sync = {ks_r.rst_sync[1:0], reset};
    if (ks_r.rst_sync[2] == ks_r.rst_sync[1]) begin
      ks_nxt.rst = ks_r.rst_sync[2];
    end
    ks_nxt.dll_sync = {ks_r.dll_sync[1:0], loop_disable_n};
    if (ks_r.dll_sync[2] == ks_r.dll_sync[1]) begin
      ks_nxt.dll_on = ks_r.dll_sync[2];
    end

    // bypassed loop drops one cycle of latency; a mode change mid-burst is not supported
    lat = ks_r.dll_on ? ddr_burst_pkg::LAT_DLL : ddr_burst_pkg::LAT_BYPASS;
    // a load right after a taken command is ignored: every second rise only
    accept = !link.load_strobe_n && !ks_r.took;
    ks_nxt.took = accept;
    ks_nxt.rd_hist = {ks_r.rd_hist[HW-2:0], accept && link.read_select};
    ks_nxt.wr_hist = {ks_r.wr_hist[HW-2:0], accept && !link.read_select};
    ks_nxt.rd_addr = {ks_r.rd_addr[AP-2:0], link.sync_address};
    ks_nxt.wr_addr = {ks_r.wr_addr[AP-2:0], link.sync_address};
    ks_nxt.tog = ~ks_r.tog;

    // read: fetch the whole burst, inverted side sends beats 0 and 2 of four
    ks_nxt.go_b0 = ks_r.rd_hist[lat-1];
    ks_nxt.go_b2 = ks_r.rd_hist[lat];
    if (ks_r.rd_hist[lat-1]) begin
      for (int b = 0; b < BL; b++) begin
        ks_nxt.rbuf[b] = mem[beat_idx(ks_r.rd_addr[lat-1], 2'(b))];
      end
    end
    ks_nxt.q_valid = ks_r.rd_hist[lat] || ks_r.rd_hist[lat+1];
    if (ks_r.rd_hist[lat]) begin
      ks_nxt.q = ks_r.rbuf[1];
    end else if (ks_r.rd_hist[lat+1]) begin
      ks_nxt.q = ks_r.rbuf[3];
    end

    // write: beat 0 one cycle after the command, beat 2 one cycle later
    if (ks_r.wr_hist[0]) begin
      ks_nxt.wb0 = link.dq;
      ks_nxt.be0 = link.byte_write_enable_n;
    end
    if (ks_r.wr_hist[1]) begin
      ks_nxt.wb2 = link.dq;
      ks_nxt.be2 = link.byte_write_enable_n;
    end

    // reset also parks the held enables at keep, so a stray store changes nothing
    if (ks_r.rst) begin
      ks_nxt.took = 1'b0;
      ks_nxt.be0 = ddr_burst_pkg::BE_NONE;
      ks_nxt.be2 = ddr_burst_pkg::BE_NONE;
      ks_nxt.rd_hist = '0;
      ks_nxt.wr_hist = '0;
      ks_nxt.go_b0 = 1'b0;
      ks_nxt.go_b2 = 1'b0;
      ks_nxt.q_valid = 1'b0;
      ks_nxt.tog = 1'b0;
      ks_nxt.dll_on = 1'b1;
    end
  end

  // inverted clock side: second and fourth write beats, first and third read beats
  always_comb begin
    ns_nxt = ns_r;
    ns_nxt.din = link.dq;
    ns_nxt.be_n = link.byte_write_enable_n;
    ns_nxt.tog = ks_r.tog;
    ns_nxt.q_valid = ks_r.go_b0 || ks_r.go_b2;
    if (ks_r.go_b0) begin
      ns_nxt.q = ks_r.rbuf[0];
    end else if (ks_r.go_b2) begin
      ns_nxt.q = ks_r.rbuf[2];
    end

    if (ks_r.rst) begin
      ns_nxt.q_valid = 1'b0;
      ns_nxt.tog = 1'b0;
      ns_nxt.be_n = ddr_burst_pkg::BE_NONE;
    end
  end

  // main clock state; the first stage of each synchroniser feeds only the second
  always_ff @(posedge link.k) begin
    ks_r <= ks_nxt;
  end

  always_ff @(posedge link.k_n) begin
    ns_r <= ns_nxt;
  end

  // write word indices; each half of the burst uses the address that is due for it
  logic [MEM_ADDR_W+1:0] wa0;
  logic [MEM_ADDR_W+1:0] wa1;
  logic [MEM_ADDR_W+1:0] wa2;
  logic [MEM_ADDR_W+1:0] wa3;
  assign wa0 = beat_idx(ks_r.wr_addr[1], 2'h0);
  assign wa1 = beat_idx(ks_r.wr_addr[1], 2'h1);
  assign wa2 = beat_idx(ks_r.wr_addr[2], 2'h2);
  assign wa3 = beat_idx(ks_r.wr_addr[2], 2'h3);

  // late write: beats 0/1 land two rises after the command, beats 2/3 one rise later
  always_ff @(posedge link.k) begin
    if (!ks_r.rst && ks_r.wr_hist[1]) begin
      mem[wa0] <= merge(mem[wa0], ks_r.wb0, ks_r.be0);
      mem[wa1] <= merge(mem[wa1], ns_r.din, ns_r.be_n);
    end

    if (!ks_r.rst && ks_r.wr_hist[2]) begin
      mem[wa2] <= merge(mem[wa2], ks_r.wb2, ks_r.be2);
      mem[wa3] <= merge(mem[wa3], ns_r.din, ns_r.be_n);
    end
  end

  // echo high after a main rise, low after an inverted rise; it steers the output mux
  assign echo = ks_r.tog ^ ns_r.tog;
  assign link.echo_clock = echo;
  assign link.inverted_echo_clock = ~echo;
  // data, enable and valid switch on the same edges as the echo pair
  assign link.dq_dev = echo ? ks_r.q : ns_r.q;
  assign link.dev_oe = echo ? ks_r.q_valid : ns_r.q_valid;
  assign link.output_valid = echo ? ks_r.q_valid : ns_r.q_valid;
  // loop state as the main clock side sees it
  assign dll_active = ks_r.dll_on;
endmodule

/* File: hdl/ddr_burst_pkg.sv */
// constants shared by both ends of the burst-of-four common-io static memory link
// assumes one link of fixed x36 width; the x18 figures are kept for reference only
package ddr_burst_pkg;
  localparam int DATA_W = 36;
  localparam int ADDR_W = 21;
  localparam int DATA_W_X18 = 18;
  localparam int ADDR_W_X18 = 22;
  localparam int BYTE_N = 4;
  localparam int BYTE_W = 9;
  localparam int BURST = 4;
  // read latency in main clock cycles, loop running and bypassed
  localparam int LAT_DLL = 2;
  localparam int LAT_BYPASS = 1;
  localparam int BYPASS_MAX_MHZ = 167;
  // command history depth, covers the longest latency plus two beats
  localparam int HIST_W = 4;
  localparam int ADDR_PIPE = 3;
  // host side: four clk edges per link cycle
  localparam logic [1:0] PH_RESET = 2'h0;
  localparam logic [1:0] PH_DRIVE_KN = 2'h0;
  localparam logic [1:0] PH_DRIVE_K = 2'h2;
  localparam logic [2:0] BEAT_DONE = 3'h4;
  localparam logic [2:0] BEAT_LAST = 3'h3;
  localparam logic [BYTE_N-1:0] BE_NONE = 4'hF;
  localparam logic [2:0] SYNC_RESET = 3'h7;
endpackage

/* File: hdl/ddr_link_if.sv */
// link between the memory controller and the memory: clocks, command, shared data
// assumes the bench joins both ends here; the shared data wire is resolved in this file
`timescale 1ns/1ps
interface ddr_link_if;
  logic k;
  logic k_n;
  logic [ddr_burst_pkg::ADDR_W-1:0] sync_address;
  logic load_strobe_n;
  logic read_select;
  logic [ddr_burst_pkg::BYTE_N-1:0] byte_write_enable_n;
  logic [ddr_burst_pkg::DATA_W-1:0] dq_host;
  logic host_oe;
  logic [ddr_burst_pkg::DATA_W-1:0] dq_dev;
  logic dev_oe;
  logic echo_clock;
  logic inverted_echo_clock;
  logic output_valid;
  wire [ddr_burst_pkg::DATA_W-1:0] dq;

  // shared bus level from the two enables; an idle bus reads as zero, as if pulled low
  assign dq = host_oe ? dq_host : (dev_oe ? dq_dev : {ddr_burst_pkg::DATA_W{1'b0}});

  modport host_end (
    output k, k_n, sync_address, load_strobe_n, read_select, byte_write_enable_n,
    output dq_host, host_oe,
    input dq, echo_clock, inverted_echo_clock, output_valid
  );
  modport device_end (
    input k, k_n, sync_address, load_strobe_n, read_select, byte_write_enable_n, dq,
    output dq_dev, dev_oe, echo_clock, inverted_echo_clock, output_valid
  );
endinterface

/* File: hdl/ddr_sram_host.sv */
// memory controller end: makes the link clocks from clk and runs one burst at a time
// assumes the memory answers on the clocks it makes, so returning data is in step with clk
`timescale 1ns/1ps
module ddr_sram_host (
  input wire logic clk,
  input wire logic reset,
  ddr_link_if.host_end link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [ddr_burst_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [ddr_burst_pkg::BURST*ddr_burst_pkg::DATA_W-1:0] cmd_wdata,
  input wire logic [ddr_burst_pkg::BURST*ddr_burst_pkg::BYTE_N-1:0] cmd_be_n,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [ddr_burst_pkg::BURST*ddr_burst_pkg::DATA_W-1:0] rd_data
);
  typedef enum logic [1:0] {h_idle, h_write, h_read, h_gap} hstate_t;

  typedef struct packed {
    logic [1:0] ph;
    logic k;
    logic k_n;
    logic load_n;
    logic rsel;
    logic [ddr_burst_pkg::ADDR_W-1:0] addr;
    logic [ddr_burst_pkg::BYTE_N-1:0] be_n;
    logic [ddr_burst_pkg::DATA_W-1:0] dq;
    logic oe;
    hstate_t st;
    logic [2:0] bcnt;
    logic [ddr_burst_pkg::BURST-1:0][ddr_burst_pkg::DATA_W-1:0] wd;
    logic [ddr_burst_pkg::BURST-1:0][ddr_burst_pkg::BYTE_N-1:0] wbe;
    logic [ddr_burst_pkg::BURST-1:0][ddr_burst_pkg::DATA_W-1:0] rd;
    logic rd_valid;
    logic ready;
  } host_t;

  host_t hs_r;
  host_t hs_nxt;
  logic drv_k;
  logic drv_kn;

  // pins change a clk edge away from either sampling edge, so no race with the memory
  always_comb begin
    hs_nxt = hs_r;
    hs_nxt.ph = hs_r.ph + 2'h1;
    hs_nxt.k = ~hs_nxt.ph[1];
    hs_nxt.k_n = hs_nxt.ph[1];
    hs_nxt.rd_valid = 1'b0;
    drv_k = (hs_r.ph == ddr_burst_pkg::PH_DRIVE_K);
    drv_kn = (hs_r.ph == ddr_burst_pkg::PH_DRIVE_KN);
    unique case (hs_r.st)
      h_idle: begin
        if (drv_k && cmd_valid && hs_r.ready) begin
          hs_nxt.load_n = 1'b0;
          hs_nxt.rsel = ~cmd_write;
          hs_nxt.addr = cmd_addr;
          hs_nxt.wd = cmd_wdata;
          hs_nxt.wbe = cmd_be_n;
          hs_nxt.bcnt = 3'h0;
          hs_nxt.st = cmd_write ? h_write : h_read;
        end
      end
      h_write: begin
        // beat 0 goes out one cycle after the command, then every half cycle
        if (drv_k || (drv_kn && hs_r.bcnt != 3'h0)) begin
          hs_nxt.load_n = 1'b1;
          if (hs_r.bcnt == ddr_burst_pkg::BEAT_DONE) begin
            hs_nxt.oe = 1'b0;
            hs_nxt.be_n = ddr_burst_pkg::BE_NONE;
            hs_nxt.st = h_idle;
          end else begin
            hs_nxt.dq = hs_r.wd[hs_r.bcnt[1:0]];
            hs_nxt.be_n = hs_r.wbe[hs_r.bcnt[1:0]];
            hs_nxt.oe = 1'b1;
            hs_nxt.bcnt = hs_r.bcnt + 3'h1;
          end
        end
      end
      h_read: begin
        if (drv_k) begin
          hs_nxt.load_n = 1'b1;
        end
        // sample mid-beat, qualified by the valid strobe, so either latency works
        if ((drv_k || drv_kn) && link.output_valid) begin
          hs_nxt.rd[hs_r.bcnt[1:0]] = link.dq;
          hs_nxt.bcnt = hs_r.bcnt + 3'h1;
          if (hs_r.bcnt == ddr_burst_pkg::BEAT_LAST) begin
            hs_nxt.rd_valid = 1'b1;
            hs_nxt.st = h_gap;
          end
        end
      end
      h_gap: begin
        if (drv_k) begin
          hs_nxt.st = h_idle;
        end
      end
    endcase
    // one-cycle window per link cycle, and never right after a command
    hs_nxt.ready = (hs_nxt.st == h_idle) && (hs_nxt.ph == ddr_burst_pkg::PH_DRIVE_K);
    if (reset) begin
      hs_nxt = '0;
      hs_nxt.ph = ddr_burst_pkg::PH_RESET;
      hs_nxt.k = 1'b1;
      hs_nxt.load_n = 1'b1;
      hs_nxt.be_n = ddr_burst_pkg::BE_NONE;
      hs_nxt.st = h_idle;
    end
  end

  // whole host state
  always_ff @(posedge clk) begin
    hs_r <= hs_nxt;
  end

  assign link.k = hs_r.k;
  assign link.k_n = hs_r.k_n;
  assign link.sync_address = hs_r.addr;
  assign link.load_strobe_n = hs_r.load_n;
  assign link.read_select = hs_r.rsel;
  assign link.byte_write_enable_n = hs_r.be_n;
  assign link.dq_host = hs_r.dq;
  assign link.host_oe = hs_r.oe;
  assign cmd_ready = hs_r.ready;
  assign rd_valid = hs_r.rd_valid;
  assign rd_data = hs_r.rd;
endmodule

/* File: dv/ddr_link_asserts.sv */
// link checker: load strobe length, write beats, read beats and echo clocks
// assumes the controller makes the link clocks from clk, so clk sees every link edge
`timescale 1ns/1ps
module ddr_link_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic k,
  input wire logic k_n,
  input wire logic load_strobe_n,
  input wire logic read_select,
  input wire logic [ddr_burst_pkg::BYTE_N-1:0] byte_write_enable_n,
  input wire logic [ddr_burst_pkg::DATA_W-1:0] dq_host,
  input wire logic host_oe,
  input wire logic [ddr_burst_pkg::DATA_W-1:0] dq_dev,
  input wire logic dev_oe,
  input wire logic echo_clock,
  input wire logic inverted_echo_clock,
  input wire logic output_valid,
  input wire logic [ddr_burst_pkg::DATA_W-1:0] dq,
  input wire logic dll_active
);
  // link edges and commands are all clk-synchronous, one domain suffices
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_LINK_CLOCK: assert property (
    $rose(k) |-> !k_n ##4 $rose(k)) else $error("link clock period wrong");
  AST_LOAD_ONE_CYCLE: assert property (
    $fell(load_strobe_n) |-> !load_strobe_n [*4] ##1 load_strobe_n) else $error("load strobe length wrong");
  AST_WRITE_BEATS: assert property (
    $fell(load_strobe_n) && !read_select |-> ##4 host_oe [*8] ##1 !host_oe) else $error("write beats misplaced");
  AST_READ_LAT_DLL: assert property (
    $fell(load_strobe_n) && read_select && dll_active |-> ##11 output_valid [*8] ##1 !output_valid)
    else $error("read beats late or early");
  AST_READ_LAT_BYPASS: assert property (
    $fell(load_strobe_n) && read_select && !dll_active |-> ##7 output_valid [*8] ##1 !output_valid)
    else $error("bypass read beats misplaced");
  AST_ECHO_TRACKS: assert property (
    output_valid |-> echo_clock == k && inverted_echo_clock == !echo_clock) else $error("echo clock off");
  AST_VALID_DRIVES: assert property (
    output_valid || dev_oe |-> output_valid && dev_oe && dq == dq_dev) else $error("valid and drive differ");
  AST_NO_CLASH: assert property (
    dev_oe |-> !host_oe) else $error("both ends drive the bus");
  AST_BEAT_STABLE: assert property (
    host_oe && $changed(k) |-> $stable(dq_host) && $stable(byte_write_enable_n)) else $error("beat moved at edge");
  AST_ENABLES_IDLE: assert property (
    $fell(host_oe) |-> byte_write_enable_n == ddr_burst_pkg::BE_NONE) else $error("enables left active");
endmodule

/* File: dv/ddr_burst4_common_io_sram_port_tb.sv */
// bench: controller and memory joined by the link, user port driven by tasks
// assumes the controller makes the link clock itself, so the bench makes only clk
`timescale 1ns/1ps
module ddr_burst4_common_io_sram_port_tb;
  localparam int W = ddr_burst_pkg::BURST*ddr_burst_pkg::DATA_W;
  localparam int BW = ddr_burst_pkg::BURST*ddr_burst_pkg::BYTE_N;
  localparam int AW = ddr_burst_pkg::ADDR_W;
  localparam logic [W-1:0] P0 = {36'h123456789, 36'hABCDEF012, 36'h3456789AB, 36'hCDEF01234};
  localparam logic [AW-1:0] ADR [3] = '{21'h00000, 21'h00001, 21'h003FF};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic dev_reset = 1'b1;
  logic loop_disable_n = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [AW-1:0] cmd_addr = '0;
  logic [W-1:0] cmd_wdata = '0;
  logic [BW-1:0] cmd_be_n = '1;
  logic cmd_ready, rd_valid, dll_active;
  logic [W-1:0] rd_data, got;
  int err_total = 0;
  int n_tests = 0;
  int lat_on, lat_off;

  ddr_link_if link();
  ddr_sram_host ddr_sram_host_inst (.clk(clk), .reset(reset), .link(link), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_be_n(cmd_be_n),
    .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data));
  // small array keeps the memory cheap; upper address bits are ignored
  ddr_sram_device #(.MEM_ADDR_W(10)) ddr_sram_device_inst (.link(link), .reset(dev_reset),
    .loop_disable_n(loop_disable_n), .dll_active(dll_active));
  ddr_link_asserts ddr_link_asserts_inst (.clk(clk), .reset(reset), .k(link.k), .k_n(link.k_n),
    .load_strobe_n(link.load_strobe_n), .read_select(link.read_select),
    .byte_write_enable_n(link.byte_write_enable_n), .dq_host(link.dq_host), .host_oe(link.host_oe),
    .dq_dev(link.dq_dev), .dev_oe(link.dev_oe), .echo_clock(link.echo_clock),
    .inverted_echo_clock(link.inverted_echo_clock), .output_valid(link.output_valid), .dq(link.dq),
    .dll_active(dll_active));

  // 10 MHz main clock
  always #50 clk = ~clk;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [W-1:0] g, input logic [W-1:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // holds the command until the edge where ready is seen; entered just after an edge
  task automatic issue(input logic wr, input logic [AW-1:0] a, input logic [W-1:0] d, input logic [BW-1:0] be);
    int i;
    step(1); // a valid dropped by the last call stays low across one edge
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_be_n = be;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (cmd_ready === 1'b1) break;
    end
    #1;
    cmd_valid = 1'b0;
    if (i == 60) begin
      err_total++;
      final_report();
    end
  endtask

  // t counts clk edges from the take edge to the one that sees rd_valid
  task automatic rd(input logic [AW-1:0] a, output logic [W-1:0] d, output int t);
    issue(1'b0, a, '0, '1);
    for (t = 1; t < 60; t++) begin
      @(posedge clk);
      if (rd_valid === 1'b1) break;
    end
    d = rd_data;
    #1;
    if (t == 60) begin
      err_total++;
      final_report();
    end
  endtask

  // low enable takes the new byte, high keeps the old one
  function automatic logic [W-1:0] merge(input logic [W-1:0] o, input logic [W-1:0] n, input logic [BW-1:0] be);
    merge = o;
    for (int j = 0; j < BW; j++) begin
      if (!be[j]) begin
        merge[j*9 +: 9] = n[j*9 +: 9];
      end
    end
  endfunction

  // main sequence; memory reset needs the link clock running, so it ends later
  initial begin
    step(16);
    reset = 1'b0;
    step(32);
    dev_reset = 1'b0;
    step(40);
    chk_val({31'h0, dll_active}, 32'h1);
    issue(1'b1, 21'h00006, P0, '0);
    rd(21'h00006, got, lat_on);
    chk_data(got, P0);
    issue(1'b1, 21'h00006, ~P0, 16'h8421);
    rd(21'h00006, got, lat_on);
    chk_data(got, merge(P0, ~P0, 16'h8421));
    // writes back to back, the top of the array among them
    for (int n = 0; n < 3; n++) begin
      issue(1'b1, ADR[n], P0 + W'(n), '0);
    end
    for (int n = 0; n < 3; n++) begin
      rd(ADR[n], got, lat_on);
      chk_data(got, P0 + W'(n));
    end
    // loop bypass shortens latency by one link cycle, four clk
    loop_disable_n = 1'b0;
    step(40);
    chk_val({31'h0, dll_active}, 32'h0);
    rd(ADR[2], got, lat_off);
    chk_data(got, P0 + W'(2));
    chk_val(32'(lat_off), 32'(lat_on - 4));
    loop_disable_n = 1'b1;
    step(40);
    chk_val({31'h0, dll_active}, 32'h1);
    rd(ADR[1], got, lat_off);
    chk_data(got, P0 + W'(1));
    chk_val(32'(lat_off), 32'(lat_on));
    final_report();
  end
endmodule
